// ---- bsr_regs.svh ----
`ifndef BSR_REGS_SVH
`define BSR_REGS_SVH
`define BSR_ADDR_A_NORM 8'h3C
`define BSR_ADDR_A_STBY 8'h3D
`define BSR_ADDR_A_SLEEP 8'h3E
`define BSR_ADDR_A_MODE 8'h3F
`define BSR_ADDR_A_CONF 8'h40
`define BSR_ADDR_B_NORM 8'h43
`define BSR_ADDR_B_STBY 8'h44
`define BSR_ADDR_B_SLEEP 8'h45
`define BSR_ADDR_B_MODE 8'h46
`define BSR_ADDR_B_CONF 8'h47
`define BSR_RANGE_BIT 6
`define BSR_SETPT_RST 6'h00
`define BSR_MODE_RST 8'h00
`define BSR_CONF_RST 8'h00
`define BSR_MODE_MASK 8'h2F
`define BSR_LOW_BASE_MV 16'h0190
`define BSR_LOW_STEP_MV 16'h0019
`define BSR_HIGH_BASE_MV 16'h0320
`define BSR_HIGH_STEP_MV 16'h0032
`define BSR_HIGH_MAX_CODE 6'h32
`endif

// ---- bsr_pkg.sv ----
package bsr_pkg;
    // Operating state of the regulator pair
    typedef enum logic [2:0] {
        BSR_NORMAL = 3'b001,
        BSR_STANDBY = 3'b010,
        BSR_SLEEP = 3'b100
    } bsr_opmode_t;
    // Register write/read request from the control interface
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } bsr_req_t;
    // Per output target handed to the analog loop
    typedef struct packed {
        logic [6:0] code;
        logic [15:0] mv;
        logic reserved;
    } bsr_target_t;
endpackage

// ---- bsr_setpoint_regs.sv ----
`timescale 1ns/1ps
`include "bsr_regs.svh"
module bsr_setpoint_regs
    import bsr_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Register access from the control interface, same clock
    input wire bsr_req_t i_req,
    output logic [7:0] o_rdata,
    output logic o_rvalid,
    // Factory configuration load of the range bits
    input wire logic i_cfg_load,
    input wire logic i_range_a,
    input wire logic i_range_b,
    // Operating state and merged single-phase select
    input wire bsr_opmode_t i_opmode,
    input wire logic i_merged,
    // Targets, mode and config copies for the two regulators
    output bsr_target_t o_target_a,
    output bsr_target_t o_target_b,
    output logic [7:0] o_mode_a,
    output logic [7:0] o_mode_b,
    output logic [7:0] o_conf_a,
    output logic [7:0] o_conf_b
);
    // Stored fields; B sits at the same relative offsets as A
    logic [5:0] setpt_r [2][3];
    logic [1:0] range_r;
    logic [7:0] mode_r [2];
    logic [7:0] conf_r [2];

    // Read path and per-output targets before their output registers
    logic [7:0] rdata_nxt;
    bsr_target_t tgt_nxt [2];

    // Range bits change only on factory load, never from host writes
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
            range_r <= 2'h0;
        else if (i_cfg_load)
            range_r <= {i_range_b, i_range_a};
    end

    // Per output: decode, storage, state select and code conversion
    // Both outputs share one loop so A and B cannot drift apart in behaviour
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_out
            // Register addresses of this output
            localparam logic [7:0] ADDR_NORM = (g == 0) ? `BSR_ADDR_A_NORM : `BSR_ADDR_B_NORM;
            localparam logic [7:0] ADDR_STBY = (g == 0) ? `BSR_ADDR_A_STBY : `BSR_ADDR_B_STBY;
            localparam logic [7:0] ADDR_SLEEP = (g == 0) ? `BSR_ADDR_A_SLEEP : `BSR_ADDR_B_SLEEP;
            localparam logic [7:0] ADDR_MODE = (g == 0) ? `BSR_ADDR_A_MODE : `BSR_ADDR_B_MODE;
            localparam logic [7:0] ADDR_CONF = (g == 0) ? `BSR_ADDR_A_CONF : `BSR_ADDR_B_CONF;
            // Write strobes and the set point chosen by the operating state
            logic [4:0] hit;
            logic [5:0] sp;

            // One write strobe per register; a write to an unmapped address hits nothing
            // Strobes are qualified by wr so a read never disturbs a register
            always_comb
            begin
                hit = 5'h00;
                if (i_req.wr)
                begin
                    hit[0] = (i_req.addr == ADDR_NORM);
                    hit[1] = (i_req.addr == ADDR_STBY);
                    hit[2] = (i_req.addr == ADDR_SLEEP);
                    hit[3] = (i_req.addr == ADDR_MODE);
                    hit[4] = (i_req.addr == ADDR_CONF);
                end
            end

            // Set points store bits 5:0 only; bits 7:6 of a write drop silently
            always_ff @(posedge i_clk)
            begin
                if (!i_rst_n)
                begin
                    setpt_r[g][0] <= `BSR_SETPT_RST;
                    setpt_r[g][1] <= `BSR_SETPT_RST;
                    setpt_r[g][2] <= `BSR_SETPT_RST;
                end
                else
                begin
                    if (hit[0])
                        setpt_r[g][0] <= i_req.wdata[5:0];
                    if (hit[1])
                        setpt_r[g][1] <= i_req.wdata[5:0];
                    if (hit[2])
                        setpt_r[g][2] <= i_req.wdata[5:0];
                end
            end

            // Mode keeps only its defined bits, so the unused ones always read zero
            always_ff @(posedge i_clk)
            begin
                if (!i_rst_n)
                    mode_r[g] <= `BSR_MODE_RST;
                else if (hit[3])
                    mode_r[g] <= i_req.wdata & `BSR_MODE_MASK;
            end

            // Config takes all eight bits as written
            always_ff @(posedge i_clk)
            begin
                if (!i_rst_n)
                    conf_r[g] <= `BSR_CONF_RST;
                else if (hit[4])
                    conf_r[g] <= i_req.wdata;
            end

            // Standby and sleep values act only while the state asks for them
            always_comb
            begin
                case (i_opmode)
                    BSR_NORMAL: sp = setpt_r[g][0];
                    BSR_STANDBY: sp = setpt_r[g][1];
                    BSR_SLEEP: sp = setpt_r[g][2];
                    default: sp = setpt_r[g][0];
                endcase
            end

            // One range bit serves all three states, so a state change never flips range
            // Reserved high codes are only flagged; nothing here keeps them from the loop
            always_comb
            begin
                tgt_nxt[g].code = {range_r[g], sp};
                if (range_r[g])
                begin
                    tgt_nxt[g].mv = `BSR_HIGH_BASE_MV + 16'(sp) * `BSR_HIGH_STEP_MV;
                    tgt_nxt[g].reserved = (sp > `BSR_HIGH_MAX_CODE);
                end
                else
                begin
                    tgt_nxt[g].mv = `BSR_LOW_BASE_MV + 16'(sp) * `BSR_LOW_STEP_MV;
                    tgt_nxt[g].reserved = 1'b0;
                end
            end
        end
    endgenerate

    // Read mux; unmapped addresses read zero
    always_comb
    begin
        case (i_req.addr)
            `BSR_ADDR_A_NORM: rdata_nxt = {1'b0, range_r[0], setpt_r[0][0]};
            `BSR_ADDR_A_STBY: rdata_nxt = {1'b0, range_r[0], setpt_r[0][1]};
            `BSR_ADDR_A_SLEEP: rdata_nxt = {1'b0, range_r[0], setpt_r[0][2]};
            `BSR_ADDR_A_MODE: rdata_nxt = mode_r[0];
            `BSR_ADDR_A_CONF: rdata_nxt = conf_r[0];
            `BSR_ADDR_B_NORM: rdata_nxt = {1'b0, range_r[1], setpt_r[1][0]};
            `BSR_ADDR_B_STBY: rdata_nxt = {1'b0, range_r[1], setpt_r[1][1]};
            `BSR_ADDR_B_SLEEP: rdata_nxt = {1'b0, range_r[1], setpt_r[1][2]};
            `BSR_ADDR_B_MODE: rdata_nxt = mode_r[1];
            `BSR_ADDR_B_CONF: rdata_nxt = conf_r[1];
            default: rdata_nxt = 8'h00;
        endcase
    end

    // Read data registered, one cycle after the request
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            o_rdata <= 8'h00;
            o_rvalid <= 1'b0;
        end
        else
        begin
            o_rvalid <= i_req.rd;
            o_rdata <= i_req.rd ? rdata_nxt : 8'h00;
        end
    end

    // Targets registered; merged mode drives B from the A registers
    // The register costs a cycle but keeps decode glitches off the analog side
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            o_target_a <= '0;
            o_target_b <= '0;
        end
        else
        begin
            o_target_a <= tgt_nxt[0];
            o_target_b <= i_merged ? tgt_nxt[0] : tgt_nxt[1];
        end
    end

    // Mode copies; a merged pair runs from the A mode register
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            o_mode_a <= `BSR_MODE_RST;
            o_mode_b <= `BSR_MODE_RST;
        end
        else
        begin
            o_mode_a <= mode_r[0];
            o_mode_b <= i_merged ? mode_r[0] : mode_r[1];
        end
    end

    // Config copies; a merged pair runs from the A config register
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            o_conf_a <= `BSR_CONF_RST;
            o_conf_b <= `BSR_CONF_RST;
        end
        else
        begin
            o_conf_a <= conf_r[0];
            o_conf_b <= i_merged ? conf_r[0] : conf_r[1];
        end
    end
endmodule

// ---- bsr_props.sv ----
`timescale 1ns/1ps
module bsr_props
    import bsr_pkg::*;
(
    // Watched ports
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire bsr_req_t i_req,
    input wire logic [7:0] o_rdata,
    input wire logic o_rvalid,
    input wire logic i_cfg_load,
    input wire logic i_range_a,
    input wire logic i_merged,
    input wire bsr_target_t o_target_a,
    input wire bsr_target_t o_target_b,
    input wire logic [7:0] o_mode_a
);
    logic rng_r;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // Shadow range bit; the bank shows it on reads and as bit 6 of the target code
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
            rng_r <= 1'b0;
        else if (i_cfg_load)
            rng_r <= i_range_a;
    end
    // Read answer and field checks
    read_pulse_a: assert property (o_rvalid == $past(i_req.rd)) else $error("rvalid");
    volt_read_a: assert property (o_rvalid && $past(i_req.addr) inside {8'h3C, 8'h3D, 8'h3E}
        |-> o_rdata[7:6] == {1'b0, $past(rng_r)}) else $error("range bits");
    low_mv_a: assert property ($past(i_rst_n) && !o_target_a.code[6]
        |-> o_target_a.mv == 16'h0190 + 16'h0019 * o_target_a.code[5:0]) else $error("low mv");
    high_mv_a: assert property ($past(i_rst_n) && o_target_a.code[6]
        |-> o_target_a.mv == 16'h0320 + 16'h0032 * o_target_a.code[5:0]) else $error("high mv");
    rsv_flag_a: assert property ($past(i_rst_n)
        |-> o_target_a.reserved == (o_target_a.code[6] && o_target_a.code[5:0] > 6'h32)) else $error("rsv");
    merge_copy_a: assert property ($past(i_merged) && $past(i_rst_n) && $stable(o_target_a)
        |-> o_target_b == o_target_a) else $error("merge");
    mode_mask_a: assert property ((o_mode_a & 8'hD0) == 8'h00) else $error("mode");
    unmapped_read_a: assert property (o_rvalid && !($past(i_req.addr) inside {[8'h3C:8'h40], [8'h43:8'h47]})
        |-> o_rdata == 8'h00) else $error("unmapped");
    cover property (o_rvalid && o_rdata[6]);
    cover property (i_merged && o_target_b.code[6]);
    cover property (o_target_a.code == 7'h72);
    cover property (o_target_b.reserved);
endmodule
bind bsr_setpoint_regs bsr_props i_bsr_props (.*);

// ---- bsr_host.sv ----
`timescale 1ns/1ps
module bsr_host
    import bsr_pkg::*;
(
    // Bus to the bank
    input wire logic i_clk,
    input wire logic [7:0] i_rdata,
    output bsr_req_t o_req
);
    initial o_req = '0;
    // One-cycle request; the task passes any data, and the 3F left on B becomes a reserved high code after the range reload
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(negedge i_clk);
        o_req = '{w, !w, a, d};
        @(negedge i_clk);
        o_req = '0;
        q = i_rdata;
    endtask
endmodule

// ---- bsr_setpoint_regs_tb.sv ----
`timescale 1ns/1ps
module bsr_setpoint_regs_tb
    import bsr_pkg::*;
;
    logic clk = 0, rst_n = 0, ld = 0, merged = 0;
    bsr_req_t req;
    bsr_opmode_t opm = BSR_NORMAL;
    bsr_target_t ta, tgb;
    logic [7:0] rdata, q;
    logic rng_a = 1, rng_b = 0;
    logic [7:0] mda, mdb, cfa, cfb;
    int mismatches = 0, n_compared = 0;
    // Packed {code A, reserved A, code B, reserved B} per state
    logic [15:0] cd[3] = '{16'hE47E, 16'hC848, 16'h8000};
    // Address, write value, expected readback
    logic [7:0] ad[8] = '{8'h3C, 8'h3D, 8'h3F, 8'h40, 8'h43, 8'h44, 8'h47, 8'h41};
    logic [7:0] wd[8] = '{8'hB2, 8'hE4, 8'hFF, 8'hA5, 8'hFF, 8'hE4, 8'h5A, 8'hFF};
    logic [7:0] ex[8] = '{8'h72, 8'h64, 8'h2F, 8'hA5, 8'h3F, 8'h24, 8'h5A, 8'h00};
    logic [15:0] mv[6] = '{16'h0CE4, 16'h0A28, 16'h0320, 16'h07B7, 16'h0514, 16'h0190};
    initial forever #12.5 clk = ~clk;
    bsr_host i_bsr_host (.i_clk(clk), .i_rdata(rdata), .o_req(req));
    bsr_setpoint_regs i_bsr_setpoint_regs (.i_clk(clk), .i_rst_n(rst_n), .i_req(req), .o_rdata(rdata),
        .o_rvalid(), .i_cfg_load(ld), .i_range_a(rng_a), .i_range_b(rng_b), .i_opmode(opm), .i_merged(merged),
        .o_target_a(ta), .o_target_b(tgb), .o_mode_a(mda), .o_mode_b(mdb), .o_conf_a(cfa), .o_conf_b(cfb));
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_compared++;
        if (g !== e)
        begin
            mismatches++;
            $display("wrong value at %0t: %h vs %h", $time, g, e);
        end
    endtask
    task automatic finish_test;
        if (mismatches == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Reset values, range load, writes, then per-state targets
    initial
    begin
        repeat (10) @(negedge clk);
        rst_n = 1;
        foreach (ad[i])
        begin
            i_bsr_host.access(0, ad[i], 8'h00, q);
            chk(q, 16'h0000);
        end
        ld = 1;
        @(negedge clk);
        ld = 0;
        foreach (ad[i])
        begin
            i_bsr_host.access(1, ad[i], wd[i], q);
            i_bsr_host.access(0, ad[i], 8'h00, q);
            chk(q, ex[i]);
        end
        chk({mda, mdb}, 16'h2F00);
        chk({cfa, cfb}, 16'hA55A);
        for (int s = 0; s < 3; s++)
        begin
            opm = bsr_opmode_t'(3'b001 << s);
            repeat (3) @(negedge clk);
            chk(ta.mv, mv[s]);
            chk(tgb.mv, mv[s + 3]);
            chk({ta.code, ta.reserved, tgb.code, tgb.reserved}, cd[s]);
        end
        merged = 1;
        repeat (3) @(negedge clk);
        chk(tgb.mv, mv[2]);
        chk({ta.code, ta.reserved, tgb.code, tgb.reserved}, 16'h8080);
        chk({mda, mdb}, 16'h2F2F);
        chk({cfa, cfb}, 16'hA5A5);
        // Factory reload swaps the ranges; stored set points keep their values
        merged = 0;
        opm = BSR_NORMAL;
        rng_a = 0;
        rng_b = 1;
        ld = 1;
        @(negedge clk);
        ld = 0;
        repeat (3) @(negedge clk);
        chk({ta.code, ta.reserved, tgb.code, tgb.reserved}, 16'h64FF);
        chk(ta.mv, 16'h0672);
        i_bsr_host.access(0, 8'h3C, 8'h00, q);
        chk(q, 16'h0032);
        i_bsr_host.access(0, 8'h44, 8'h00, q);
        chk(q, 16'h0064);
        finish_test();
    end
endmodule
